// File: hbm_pkg.sv
// hbm_pkg: constants and carrier types for the h-bridge motor drive control
// assumes a 20 MHz core clock and a plain strobe register port
package hbm_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned RETRY_US = 1000;
	localparam int unsigned RETRY_CYC = RETRY_US * (CLK_HZ / 1000000);
	localparam int unsigned DEGLITCH_NS = 3000;
	localparam int unsigned DEGLITCH_CYC_RAW = (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned DEGLITCH_CYC = (DEGLITCH_CYC_RAW < 1) ? 1 : DEGLITCH_CYC_RAW;
	localparam int unsigned CNT_W = 16;
	// register map: byte addresses
	localparam logic [7:0] REG_MOTOR_CTRL = 8'h0F;
	localparam logic [7:0] REG_MOTOR_STAT = 8'h3C;
	// field positions inside the motor control word
	localparam int unsigned FLD_B_SECOND = 0;
	localparam int unsigned FLD_B_FIRST = 1;
	localparam int unsigned FLD_A_SECOND = 2;
	localparam int unsigned FLD_A_FIRST = 3;
	localparam int unsigned FLD_SCHEME = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		HBM_COAST,
		HBM_REVERSE,
		HBM_FORWARD,
		HBM_BRAKE
	} hbm_drive_e;

	typedef enum {
		HBM_RUN,
		HBM_OFF
	} hbm_prot_e;

	// one bridge's pin drive: value and output enable for each output
	typedef struct packed {
		logic out_one;
		logic out_one_oe;
		logic out_two;
		logic out_two_oe;
	} hbm_pins_s;

	typedef struct packed {
		hbm_prot_e st;
		logic [CNT_W-1:0] cnt;
	} hbm_prot_s;
endpackage : hbm_pkg

// File: hbm_motor_ctrl.sv
// hbm_motor_ctrl: decode and overcurrent retry for two h-bridges
// assumes synchronous register strobes and current-limit flags from the analog side
// Notes on behaviour
// - scheme pin low or floating with control bit 4 clear selects two-input decode; pin high or bit 4 set selects phase/enable
// - bridge A controls from bits 3:2, bridge B from bits 1:0 of control word
// - two-input: 00 coast, 01 reverse, 10 forward, 11 brake
// - phase/enable: enable 0 brakes; phase 1 reverse, phase 0 forward
// - current limit held past deglitch time disables whole affected bridge
// - disabled bridge re-enables automatically about one millisecond later
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module hbm_motor_ctrl
	import hbm_pkg::*;
#(
	parameter int unsigned RETRY_CYCLES = RETRY_CYC,
	parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic drive_scheme_select,
	input wire logic ilim_a,
	input wire logic ilim_b,
	output hbm_pins_s bridge_a,
	output hbm_pins_s bridge_b,
	output logic bridge_a_off,
	output logic bridge_b_off
);

	typedef struct packed {
		logic [4:0] ctrl;
		hbm_prot_s prot_a;
		hbm_prot_s prot_b;
		hbm_pins_s pins_a;
		hbm_pins_s pins_b;
		logic [31:0] rdata;
	} hbm_state_s;

	hbm_state_s q, d;

	////////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic hbm_drive_e decode(input logic scheme, input logic first, input logic second);
		if (!scheme) begin
			case ({first, second})
				2'h0: decode = HBM_COAST;
				2'h1: decode = HBM_REVERSE;
				2'h2: decode = HBM_FORWARD;
				default: decode = HBM_BRAKE;
			endcase
		end else if (!first) begin
			decode = HBM_BRAKE;
		end else begin
			decode = second ? HBM_REVERSE : HBM_FORWARD;
		end
	endfunction : decode

	function automatic hbm_pins_s drive(input hbm_drive_e m, input logic off);
		hbm_pins_s p;
		p = '0;
		if (!off) begin
			case (m)
				HBM_REVERSE: begin
					p.out_one = 1'b0;
					p.out_one_oe = 1'b1;
					p.out_two = 1'b1;
					p.out_two_oe = 1'b1;
				end
				HBM_FORWARD: begin
					p.out_one = 1'b1;
					p.out_one_oe = 1'b1;
					p.out_two = 1'b0;
					p.out_two_oe = 1'b1;
				end
				HBM_BRAKE: begin
					p.out_one = 1'b0;
					p.out_one_oe = 1'b1;
					p.out_two = 1'b0;
					p.out_two_oe = 1'b1;
				end
				default: begin
					// coast: both outputs released
					p = '0;
				end
			endcase
		end
		drive = p;
	endfunction : drive

	// deglitch then fixed off time, then retry
	function automatic hbm_prot_s protect(input hbm_prot_s s, input logic ilim);
		hbm_prot_s n;
		n = s;
		case (s.st)
			HBM_RUN: begin
				if (!ilim) begin
					n.cnt = '0;
				end else if (s.cnt >= CNT_W'(DEGLITCH_CYCLES - 1)) begin
					n.st = HBM_OFF;
					n.cnt = '0;
				end else begin
					n.cnt = s.cnt + 1'b1;
				end
			end
			HBM_OFF: begin
				if (s.cnt >= CNT_W'(RETRY_CYCLES - 1)) begin
					n.st = HBM_RUN;
					n.cnt = '0;
				end else begin
					n.cnt = s.cnt + 1'b1;
				end
			end
			default: begin
				n.st = HBM_RUN;
				n.cnt = '0;
			end
		endcase
		protect = n;
	endfunction : protect

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_off(input hbm_prot_s s);
		is_off = (s.st == HBM_OFF);
	endfunction : is_off

	// address match of one register, shared by both strobes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_at);
		hit = (addr == reg_at);
	endfunction : hit

	// pin high or register bit set selects phase/enable
	function automatic logic scheme_of(input logic pin, input logic [4:0] ctrl);
		scheme_of = pin | ctrl[FLD_SCHEME];
	endfunction : scheme_of

	// one bridge: decode its two control bits, then gate by its shutdown state
	function automatic hbm_pins_s bridge_pins(input logic scheme, input logic first, input logic second,
			input hbm_prot_s prot);
		bridge_pins = drive(decode(scheme, first, second), is_off(prot));
	endfunction : bridge_pins

	// registered read word; unmapped addresses read as zero
	function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [4:0] ctrl,
			input logic scheme, input logic off_a, input logic off_b);
		logic [31:0] w;
		w = RD_ZERO;
		if (hit(addr, REG_MOTOR_CTRL)) begin
			w = {27'h0, ctrl};
		end else if (hit(addr, REG_MOTOR_STAT)) begin
			// status: effective scheme, then bridge B and bridge A shutdown
			w = {29'h0, scheme, off_b, off_a};
		end else begin
			w = RD_ZERO;
		end
		read_word = w;
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic scheme;
		logic off_a;
		logic off_b;
		scheme = 1'b0;
		off_a = 1'b0;
		off_b = 1'b0;
		d = q;
		if (reg_wr && hit(reg_addr, REG_MOTOR_CTRL)) begin
			d.ctrl = reg_wdata[4:0];
		end
		scheme = scheme_of(drive_scheme_select, q.ctrl);
		off_a = is_off(q.prot_a);
		off_b = is_off(q.prot_b);
		d.prot_a = protect(q.prot_a, ilim_a);
		d.prot_b = protect(q.prot_b, ilim_b);
		// each bridge follows its own bits, one edge after they change
		d.pins_a = bridge_pins(scheme, q.ctrl[FLD_A_FIRST], q.ctrl[FLD_A_SECOND], q.prot_a);
		d.pins_b = bridge_pins(scheme, q.ctrl[FLD_B_FIRST], q.ctrl[FLD_B_SECOND], q.prot_b);
		d.rdata = RD_ZERO;
		if (reg_rd) begin
			d.rdata = read_word(reg_addr, q.ctrl, scheme, off_a, off_b);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q.ctrl <= CTRL_RESET;
			q.prot_a <= '{st: HBM_RUN, cnt: '0};
			q.prot_b <= '{st: HBM_RUN, cnt: '0};
			q.pins_a <= '0;
			q.pins_b <= '0;
			q.rdata <= RD_ZERO;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata = q.rdata;
	assign bridge_a = q.pins_a;
	assign bridge_b = q.pins_b;
	assign bridge_a_off = is_off(q.prot_a);
	assign bridge_b_off = is_off(q.prot_b);

endmodule : hbm_motor_ctrl

// File: hbm_motor_ctrl_asserts.sv
// hbm_motor_ctrl_asserts: port checks of decode and overcurrent retry
// assumes binding onto hbm_motor_ctrl with small retry count
`timescale 1ns/1ps
module hbm_motor_ctrl_asserts
	import hbm_pkg::*;
#(
	parameter int RETRY_CYCLES = 20,
	parameter int DEGLITCH_CYCLES = 3
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic drive_scheme_select,
	input wire logic ilim_a,
	input wire hbm_pins_s bridge_a,
	input wire hbm_pins_s bridge_b,
	input wire logic bridge_a_off,
	input wire logic bridge_b_off
);
	localparam int R_LO = RETRY_CYCLES - 10;
	localparam int R_HI = RETRY_CYCLES - 6;
	logic [4:0] c_q;
	hbm_pins_s ea_q;
	hbm_pins_s eb_q;
	function automatic hbm_pins_s dec(input logic m, input logic f, input logic s);
		return m ? {f & ~s, 1'b1, f & s, 1'b1} : {f & ~s, f | s, s & ~f, f | s};
	endfunction : dec
	// shadow of the control word and the pins it should give one edge later
	always_ff @(posedge core_clk) begin
		c_q <= sys_rst ? CTRL_RESET : (reg_wr && reg_addr == REG_MOTOR_CTRL) ? reg_wdata[4:0] : c_q;
		ea_q <= sys_rst ? 4'h0 : dec(drive_scheme_select | c_q[4], c_q[3], c_q[2]);
		eb_q <= sys_rst ? 4'h0 : dec(drive_scheme_select | c_q[4], c_q[1], c_q[0]);
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	dec_a_a: assert property (!$past(bridge_a_off) |-> bridge_a == ea_q)
		else $error("bridge a decode wrong");
	dec_b_a: assert property (!$past(bridge_b_off) |-> bridge_b == eb_q)
		else $error("bridge b decode wrong");
	coast_a_a: assert property (bridge_a_off |=> !bridge_a.out_one_oe && !bridge_a.out_two_oe)
		else $error("bridge a drives while off");
	trip_a_a: assert property (not ((ilim_a && !bridge_a_off) [*5]))
		else $error("bridge a limit not shut down");
	early_a_a: assert property ($rose(bridge_a_off) |-> $past(ilim_a) && $past(ilim_a, 2))
		else $error("bridge a shut down too early");
	retry_a_a: assert property ($rose(bridge_a_off) |-> bridge_a_off [*8] ##[R_LO:R_HI] !bridge_a_off)
		else $error("bridge a retry time wrong");
	retry_b_a: assert property ($rose(bridge_b_off) |-> bridge_b_off [*8] ##[R_LO:R_HI] !bridge_b_off)
		else $error("bridge b retry time wrong");
	cover property ($rose(bridge_b_off));
	cover property ($fell(bridge_a_off));
	cover property (drive_scheme_select && bridge_a.out_two);
endmodule : hbm_motor_ctrl_asserts
bind hbm_motor_ctrl hbm_motor_ctrl_asserts #(.RETRY_CYCLES(RETRY_CYCLES), .DEGLITCH_CYCLES(DEGLITCH_CYCLES))
	u_chk (.*);

// File: hbm_motor_model.sv
// hbm_motor_model: winding on one bridge
// assumes a stall drives the current to the limit while driven apart
`timescale 1ns/1ps
module hbm_motor_model
	import hbm_pkg::*;
(
	input wire hbm_pins_s pins,
	input wire logic stall,
	output logic ilim
);
	assign ilim = stall && pins.out_one_oe && pins.out_two_oe && (pins.out_one != pins.out_two);
endmodule : hbm_motor_model

// File: hbm_motor_ctrl_tb.sv
// hbm_motor_ctrl_tb: register driven checks of both bridges
// assumes retry 20 and deglitch 3 cycles
`timescale 1ns/1ps
module hbm_motor_ctrl_tb
	import hbm_pkg::*;
;
	logic core_clk, sys_rst, reg_wr, reg_rd, pin, st_a, st_b, ia, ib, off_a, off_b;
	logic [7:0] addr;
	logic [31:0] wd, rdata;
	hbm_pins_s pa, pb;
	int n_mismatch = 0, tests_run = 0, n;
	hbm_motor_ctrl #(.RETRY_CYCLES(20), .DEGLITCH_CYCLES(3)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.drive_scheme_select(pin), .ilim_a(ia), .ilim_b(ib), .bridge_a(pa), .bridge_b(pb),
		.bridge_a_off(off_a), .bridge_b_off(off_b));
	hbm_motor_model ma (.pins(pa), .stall(st_a), .ilim(ia));
	hbm_motor_model mb (.pins(pb), .stall(st_b), .ilim(ib));
	// expected pins {out_one, oe, out_two, oe} indexed by {scheme, first, second}
	function automatic logic [31:0] pe(input logic [2:0] k);
		return (32'h7D555D70 >> {k, 2'b00}) & 32'h0000000F;
	endfunction : pe
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wd <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#50000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, pin, st_a, st_b, addr, wd} = {1'b1, 45'h0};
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1 chk(32'(pa), 0);
		rd(8'h55, 0);
		for (int i = 0; i < 64; i++) begin
			pin <= i[5];
			wr(8'h0F, 32'(i[4:0]));
			repeat (2) @(posedge core_clk);
			#1 chk(32'(pa), pe({i[5] | i[4], i[3:2]}));
			chk(32'(pb), pe({i[5] | i[4], i[1:0]}));
			rd(8'h3C, 32'({i[5] | i[4], 2'b00}));
		end
		pin <= 1'b0;
		wr(8'h0F, 32'h09);
		st_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		st_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1 chk(32'(off_b), 0);
		st_a <= 1'b1;
		for (n = 0; n < 9 && off_a !== 1'b1; n++) #50;
		chk(32'(off_a), 1);
		st_a <= 1'b0;
		chk(32'(pb), 32'h7);
		#50 chk(32'({pa.out_one_oe, pa.out_two_oe}), 0);
		for (n = 0; n < 40 && off_a === 1'b1; n++) #50;
		chk(32'(n > 16 && n < 22), 1);
		#150 chk(32'(pa), 32'hD);
		st_b <= 1'b1;
		#500 st_b <= 1'b0;
		#1500 chk(32'(pb), 32'h7);
		close_out();
	end
endmodule : hbm_motor_ctrl_tb
